// ---- design/pmwc_defines.svh ----
// Register offsets, field positions, reset values and counts of the power mode controller.
`ifndef PMWC_DEFINES_SVH
`define PMWC_DEFINES_SVH

`define PMWC_ADDR_W 8
`define PMWC_DATA_W 8
`define PMWC_P0_W 8
`define PMWC_P1_W 8

`define PMWC_P1_WAKE_EN_OFS 8'hc0
`define PMWC_MODE_CTRL_OFS 8'hca
`define PMWC_STATUS_OFS 8'hcb

`define PMWC_HOS_BIT 1
`define PMWC_CMS_BIT 2
`define PMWC_CPUM_LSB 3
`define PMWC_CPUM_MSB 4
`define PMWC_STAT_CAUSE_LSB 5
`define PMWC_STAT_CAUSE_MSB 7

`define PMWC_P1_WAKE_EN_RST 8'h00
`define PMWC_CPUM_RST 2'b00
`define PMWC_CMS_RST 1'b0
`define PMWC_HOS_RST 1'b0

`define PMWC_CPUM_NORMAL 2'b00
`define PMWC_CPUM_SLEEP 2'b01
`define PMWC_CPUM_GREEN 2'b10
`define PMWC_CPUM_RSVD 2'b11

`define PMWC_STAB_CNT_W 12
`define PMWC_STAB_CYCLES 12'h800
`define PMWC_SLOW_DIV_W 2
`define PMWC_SLOW_DIV_LAST 2'h3

`endif

// ---- design/pmwc_pkg.sv ----
// Types shared by the power mode controller modules.
package pmwc_pkg;

    typedef enum logic [4:0] {
        PMWC_ST_NORMAL = 5'b00001,
        PMWC_ST_SLOW = 5'b00010,
        PMWC_ST_GREEN = 5'b00100,
        PMWC_ST_SLEEP = 5'b01000,
        PMWC_ST_WAKE = 5'b10000
    } pmwc_state_e;

    typedef logic [1:0] pmwc_cpum_t;

    typedef logic [2:0] pmwc_cause_t;

endpackage

// ---- design/pmwc_level_watch.sv ----
// Port level change detector with a reference frozen while the core is stopped.
`timescale 1ns/10ps
`include "pmwc_defines.svh"

module pmwc_level_watch
#(
    parameter int W = 8
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] pins_i,
    input wire logic arm_i,
    output logic [W-1:0] change_o
);

    logic [W-1:0] ref_r;
    logic [W-1:0] ref_nxt;

    // The reference follows the pins while armed and holds once the core stops.
    always_comb
    begin
        ref_nxt = arm_i ? pins_i : ref_r;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ref_r <= '0;
        else
            ref_r <= ref_nxt;
    end

    assign change_o = arm_i ? '0 : (pins_i ^ ref_r);

endmodule

// ---- design/pmwc_stab_counter.sv ----
// Oscillator stabilisation counter for the wakeup from sleep.
`timescale 1ns/10ps
`include "pmwc_defines.svh"

module pmwc_stab_counter
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clear_i,
    input wire logic count_i,
    output logic done_o
);

    logic [`PMWC_STAB_CNT_W-1:0] cnt_r;
    logic [`PMWC_STAB_CNT_W-1:0] cnt_nxt;
    logic at_last;

    assign at_last = (cnt_r == (`PMWC_STAB_CYCLES - 12'h001));

    always_comb
    begin
        cnt_nxt = cnt_r;
        if (clear_i)
            cnt_nxt = '0;
        else if (count_i && !at_last)
            cnt_nxt = cnt_r + 12'h001;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cnt_r <= '0;
        else
            cnt_r <= cnt_nxt;
    end

    // Done on the last of the counted oscillator cycles.
    assign done_o = at_last && count_i && !clear_i;

endmodule

// ---- design/pmwc_top.sv ----
// Operating mode and wakeup controller: normal, slow, green and sleep modes.
//
// Behaviour
// - Writing cpu mode 01 in normal or slow mode enters sleep.
// - Setting clock mode select switches the system clock to low RC, slow mode.
// - Clearing clock mode select returns to normal if the high oscillator stop bit is clear.
// - In slow mode the high oscillator stop bit halts the high oscillator only.
// - Sleep and green stop instruction execution until a wakeup trigger.
// - Wakeup triggers are port 0 and port 1 level changes and timer A overflow.
// - Sleep wakes only on an enabled pin change or reset, always into normal.
// - Green wakes on port change or timer A overflow into the mode it left.
// - With timer A wakeup disabled, green wakes only by enabled pin or reset.
// - The high clock oscillator is stopped in sleep mode.
// - After a sleep wakeup wait oscillator start-up plus 2048 high clocks.
// - Wakeup from green has no stabilisation wait.
// - Port 0 always wakes; each port 1 pin wakes only if its enable is set.
// - Port 1 wake enable bits 7 to 0 are write-only and reset to zero.
// - Green with timer wakeup returns on enabled pin or timer A overflow.
// - Cpu mode field: 00 normal, 01 sleep, 10 green, 11 reserved; resets 00.
// - In slow mode one instruction cycle takes four low RC clocks.
// - High oscillator stop: 0 runs, 1 stops it, low RC keeps running; resets 0. Here 1 stops it only in slow and green modes.
`timescale 1ns/10ps
`include "pmwc_defines.svh"

module pmwc_top
    import pmwc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [`PMWC_ADDR_W-1:0] reg_addr_i,
    input wire logic [`PMWC_DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [`PMWC_DATA_W-1:0] reg_rdata_o,
    input wire logic [`PMWC_P0_W-1:0] port0_pins_i,
    input wire logic [`PMWC_P1_W-1:0] port1_pins_i,
    input wire logic timer_a_enable_i,
    input wire logic timer_a_overflow_i,
    input wire logic timer_b_enable_i,
    input wire logic high_osc_ready_i,
    output logic external_high_osc_run_o,
    output logic internal_low_rc_run_o,
    output logic sys_clk_low_sel_o,
    output logic cpu_run_o,
    output logic cpu_tick_o,
    output logic timer_a_active_o,
    output logic timer_b_active_o,
    output logic timer_a_int_gate_o,
    output logic other_int_gate_o,
    output logic ext_int_gate_o,
    output logic wake_pulse_o
);

    pmwc_state_e state_r;
    pmwc_state_e state_nxt;
    pmwc_cpum_t cpu_mode_field_r;
    pmwc_cpum_t cpu_mode_field_nxt;
    logic clock_mode_select_r;
    logic clock_mode_select_nxt;
    logic high_osc_stop_r;
    logic high_osc_stop_nxt;
    logic prev_slow_r;
    logic prev_slow_nxt;
    pmwc_cause_t cause_r;
    pmwc_cause_t cause_nxt;
    logic wake_pulse_r;
    logic wake_pulse_nxt;

    logic [`PMWC_P1_W-1:0] port1_wake_enable_r;
    logic [`PMWC_P1_W-1:0] port1_wake_enable_nxt;
    logic [`PMWC_DATA_W-1:0] rdata_r;
    logic [`PMWC_DATA_W-1:0] rdata_nxt;

    logic [`PMWC_SLOW_DIV_W-1:0] slow_div_r;
    logic [`PMWC_SLOW_DIV_W-1:0] slow_div_nxt;

    logic running;
    logic stopped;
    logic wr_mode;
    logic wr_p1en;
    pmwc_cpum_t wr_cpum;
    logic [`PMWC_P0_W-1:0] p0_change;
    logic [`PMWC_P1_W-1:0] p1_change;
    logic p0_wake;
    logic p1_wake;
    logic timer_wake;
    logic pin_wake;
    logic stab_clear;
    logic stab_count;
    logic stab_done;

    assign running = (state_r == PMWC_ST_NORMAL) || (state_r == PMWC_ST_SLOW);
    assign stopped = (state_r == PMWC_ST_SLEEP) || (state_r == PMWC_ST_WAKE);
    assign wr_mode = reg_wr_i && (reg_addr_i == `PMWC_MODE_CTRL_OFS);
    assign wr_p1en = reg_wr_i && (reg_addr_i == `PMWC_P1_WAKE_EN_OFS);
    assign wr_cpum = reg_wdata_i[`PMWC_CPUM_MSB:`PMWC_CPUM_LSB];

    // Pin references are taken while instructions execute and frozen in green and sleep.
    pmwc_level_watch #(
        .W(`PMWC_P0_W)
    ) u_port0_watch (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pins_i(port0_pins_i),
        .arm_i(running),
        .change_o(p0_change)
    );

    pmwc_level_watch #(
        .W(`PMWC_P1_W)
    ) u_port1_watch (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pins_i(port1_pins_i),
        .arm_i(running),
        .change_o(p1_change)
    );

    assign p0_wake = |p0_change;
    assign p1_wake = |(p1_change & port1_wake_enable_r);
    assign pin_wake = p0_wake || p1_wake;
    assign timer_wake = timer_a_enable_i && timer_a_overflow_i;

    // The wait starts only once the restarted oscillator reports itself up.
    assign stab_clear = (state_r != PMWC_ST_WAKE);
    assign stab_count = (state_r == PMWC_ST_WAKE) && high_osc_ready_i;

    pmwc_stab_counter u_stab (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(stab_clear),
        .count_i(stab_count),
        .done_o(stab_done)
    );

    // Mode sequencing.
    always_comb
    begin
        state_nxt = state_r;
        cpu_mode_field_nxt = cpu_mode_field_r;
        clock_mode_select_nxt = clock_mode_select_r;
        high_osc_stop_nxt = high_osc_stop_r;
        prev_slow_nxt = prev_slow_r;
        cause_nxt = cause_r;
        wake_pulse_nxt = 1'b0;

        // Writes reach the mode register only while the core executes; the reserved code is dropped.
        if (wr_mode && running)
        begin
            clock_mode_select_nxt = reg_wdata_i[`PMWC_CMS_BIT];
            high_osc_stop_nxt = reg_wdata_i[`PMWC_HOS_BIT];
            if (wr_cpum != `PMWC_CPUM_RSVD)
                cpu_mode_field_nxt = wr_cpum;
        end

        case (state_r)
            PMWC_ST_NORMAL:
            begin
                if (cpu_mode_field_nxt == `PMWC_CPUM_SLEEP)
                    state_nxt = PMWC_ST_SLEEP;
                else if (cpu_mode_field_nxt == `PMWC_CPUM_GREEN)
                begin
                    state_nxt = PMWC_ST_GREEN;
                    prev_slow_nxt = 1'b0;
                end
                else if (clock_mode_select_nxt)
                    state_nxt = PMWC_ST_SLOW;
            end
            PMWC_ST_SLOW:
            begin
                if (cpu_mode_field_nxt == `PMWC_CPUM_SLEEP)
                    state_nxt = PMWC_ST_SLEEP;
                else if (cpu_mode_field_nxt == `PMWC_CPUM_GREEN)
                begin
                    state_nxt = PMWC_ST_GREEN;
                    prev_slow_nxt = 1'b1;
                end
                else if (!clock_mode_select_nxt && !high_osc_stop_nxt)
                    state_nxt = PMWC_ST_NORMAL;
            end
            PMWC_ST_GREEN:
            begin
                if (pin_wake || timer_wake)
                begin
                    state_nxt = prev_slow_r ? PMWC_ST_SLOW : PMWC_ST_NORMAL;
                    cpu_mode_field_nxt = `PMWC_CPUM_NORMAL;
                    cause_nxt = {timer_wake, p1_wake, p0_wake};
                    wake_pulse_nxt = 1'b1;
                end
            end
            PMWC_ST_SLEEP:
            begin
                if (pin_wake)
                begin
                    state_nxt = PMWC_ST_WAKE;
                    cpu_mode_field_nxt = `PMWC_CPUM_NORMAL;
                    clock_mode_select_nxt = 1'b0;
                    high_osc_stop_nxt = 1'b0;
                    cause_nxt = {1'b0, p1_wake, p0_wake};
                end
            end
            PMWC_ST_WAKE:
            begin
                if (stab_done)
                begin
                    state_nxt = PMWC_ST_NORMAL;
                    wake_pulse_nxt = 1'b1;
                end
            end
            default:
            begin
                state_nxt = PMWC_ST_NORMAL;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_r <= PMWC_ST_NORMAL;
            cpu_mode_field_r <= `PMWC_CPUM_RST;
            clock_mode_select_r <= `PMWC_CMS_RST;
            high_osc_stop_r <= `PMWC_HOS_RST;
            prev_slow_r <= 1'b0;
            cause_r <= '0;
            wake_pulse_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            cpu_mode_field_r <= cpu_mode_field_nxt;
            clock_mode_select_r <= clock_mode_select_nxt;
            high_osc_stop_r <= high_osc_stop_nxt;
            prev_slow_r <= prev_slow_nxt;
            cause_r <= cause_nxt;
            wake_pulse_r <= wake_pulse_nxt;
        end
    end

    // Slow mode instruction divider; the normal mode divider is a clock option outside.
    always_comb
    begin
        slow_div_nxt = '0;
        if (state_r == PMWC_ST_SLOW)
            slow_div_nxt = slow_div_r + 2'h1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            slow_div_r <= '0;
        else
            slow_div_r <= slow_div_nxt;
    end

    // Register file: port 1 wake enables and the read path.
    always_comb
    begin
        port1_wake_enable_nxt = port1_wake_enable_r;
        if (wr_p1en)
            port1_wake_enable_nxt = reg_wdata_i;

        rdata_nxt = '0;
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                `PMWC_MODE_CTRL_OFS:
                begin
                    rdata_nxt[`PMWC_CPUM_MSB:`PMWC_CPUM_LSB] = cpu_mode_field_r;
                    rdata_nxt[`PMWC_CMS_BIT] = clock_mode_select_r;
                    rdata_nxt[`PMWC_HOS_BIT] = high_osc_stop_r;
                end
                `PMWC_STATUS_OFS:
                begin
                    rdata_nxt[`PMWC_STAT_CAUSE_LSB-1:0] = state_r;
                    rdata_nxt[`PMWC_STAT_CAUSE_MSB:`PMWC_STAT_CAUSE_LSB] = cause_r;
                end
                default:
                begin
                    // Write-only and unmapped addresses read as zero.
                    rdata_nxt = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            port1_wake_enable_r <= `PMWC_P1_WAKE_EN_RST;
            rdata_r <= '0;
        end
        else
        begin
            port1_wake_enable_r <= port1_wake_enable_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata_o = rdata_r;
    assign wake_pulse_o = wake_pulse_r;

    // Oscillator control: the stop bit acts only in slow and green modes.
    assign external_high_osc_run_o = (state_r == PMWC_ST_NORMAL) || (state_r == PMWC_ST_WAKE) ||
        (((state_r == PMWC_ST_SLOW) || (state_r == PMWC_ST_GREEN)) && !high_osc_stop_r);
    assign internal_low_rc_run_o = (state_r != PMWC_ST_SLEEP);
    assign sys_clk_low_sel_o = (state_r == PMWC_ST_SLOW) ||
        ((state_r == PMWC_ST_GREEN) && prev_slow_r);

    // Execution and instruction rate.
    assign cpu_run_o = running;
    assign cpu_tick_o = (state_r == PMWC_ST_NORMAL) ||
        ((state_r == PMWC_ST_SLOW) && (slow_div_r == `PMWC_SLOW_DIV_LAST));

    // Timer and interrupt gating per mode.
    assign timer_a_active_o = timer_a_enable_i && !stopped;
    assign timer_b_active_o = timer_b_enable_i && running;
    assign timer_a_int_gate_o = !stopped;
    assign other_int_gate_o = running;
    assign ext_int_gate_o = !stopped;

endmodule

// ---- verif/pmwc_wake_src.sv ----
// Model of the port pins, timer overflow and high oscillator around the controller.
`timescale 1ns/10ps

module pmwc_wake_src
#(
    parameter int STARTUP = 20
)
(
    input wire logic clk_i,
    input wire logic run_i,
    input wire logic [7:0] p0_flip_i,
    input wire logic [7:0] p1_flip_i,
    input wire logic ovf_i,
    output logic [7:0] p0_o = 8'h00,
    output logic [7:0] p1_o = 8'h00,
    output logic ovf_o = 1'b0,
    output logic ready_o
);
    int cnt = 0;

    // The oscillator is stable STARTUP cycles after enabling and drops at the first clock edge after it is stopped.
    assign ready_o = (cnt >= STARTUP);

    always @(posedge clk_i)
    begin
        cnt <= run_i ? ((cnt >= STARTUP) ? cnt : cnt + 1) : 0;
        p0_o <= p0_o ^ p0_flip_i;
        p1_o <= p1_o ^ p1_flip_i;
        ovf_o <= ovf_i;
    end
endmodule

// ---- verif/pmwc_top_sva.sv ----
// Concurrent checks on the ports of the power mode controller.
`timescale 1ns/10ps
`include "pmwc_defines.svh"

module pmwc_top_chk
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [`PMWC_ADDR_W-1:0] reg_addr_i,
    input wire logic [`PMWC_DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [`PMWC_DATA_W-1:0] reg_rdata_o,
    input wire logic timer_a_enable_i,
    input wire logic timer_a_overflow_i,
    input wire logic high_osc_ready_i,
    input wire logic external_high_osc_run_o,
    input wire logic internal_low_rc_run_o,
    input wire logic sys_clk_low_sel_o,
    input wire logic cpu_run_o,
    input wire logic cpu_tick_o,
    input wire logic timer_a_active_o,
    input wire logic timer_b_active_o,
    input wire logic timer_a_int_gate_o,
    input wire logic other_int_gate_o,
    input wire logic ext_int_gate_o,
    input wire logic wake_pulse_o
);
    logic mode_wr;
    logic stab_wait;
    logic [12:0] stab_r;
    logic [12:0] stab_nxt;
    logic [2:0] gap_r;
    logic [2:0] gap_nxt;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    assign mode_wr = reg_wr_i && reg_addr_i == `PMWC_MODE_CTRL_OFS && cpu_run_o;
    // Sleep exit wait: stopped, timer interrupt gated, high oscillator enabled.
    assign stab_wait = !cpu_run_o && !timer_a_int_gate_o && external_high_osc_run_o;

    always_comb
    begin
        stab_nxt = (stab_wait && !rst_i) ? stab_r + {12'h0, high_osc_ready_i} : 13'h0;
        gap_nxt = (cpu_run_o && sys_clk_low_sel_o && !cpu_tick_o && !rst_i) ? gap_r + 3'h1 : 3'h0;
    end

    always_ff @(posedge clk_i)
    begin
        stab_r <= stab_nxt;
        gap_r <= gap_nxt;
    end

    wo_read_a: assert property ($past(reg_rd_i) && $past(reg_addr_i) == `PMWC_P1_WAKE_EN_OFS |-> reg_rdata_o == 8'h00)
        else $error("wake enable register read back nonzero");
    sleep_entry_a: assert property (mode_wr && reg_wdata_i[4:3] == 2'b01 |=>
        !cpu_run_o && !external_high_osc_run_o && !internal_low_rc_run_o) else $error("sleep not entered");
    green_entry_a: assert property (mode_wr && reg_wdata_i[4:3] == 2'b10 |=> !cpu_run_o && timer_a_int_gate_o
        && ext_int_gate_o && !other_int_gate_o && !timer_b_active_o) else $error("green not entered");
    sleep_gate_a: assert property (!internal_low_rc_run_o |-> !timer_a_active_o && !timer_b_active_o
        && !timer_a_int_gate_o && !other_int_gate_o && !ext_int_gate_o) else $error("sleep gating open");
    halt_tick_a: assert property (!cpu_run_o |-> !cpu_tick_o)
        else $error("instruction tick while stopped");
    slow_tick_a: assert property (cpu_run_o && sys_clk_low_sel_o && cpu_tick_o ##1 sys_clk_low_sel_o |-> !cpu_tick_o)
        else $error("slow ticks back to back");
    slow_gap_a: assert property (gap_r <= 3'h3)
        else $error("slow tick gap above four");
    timer_wake_a: assert property (!cpu_run_o && timer_a_int_gate_o && timer_a_enable_i && timer_a_overflow_i
        |=> cpu_run_o && wake_pulse_o) else $error("green timer wakeup late");
    stab_wait_a: assert property (stab_wait ##1 cpu_run_o |-> stab_r == 13'h0800)
        else $error("sleep exit wait not 2048 cycles");
    wake_pulse_a: assert property (wake_pulse_o |-> cpu_run_o && !$past(cpu_run_o))
        else $error("wake pulse out of place");
endmodule

bind pmwc_top pmwc_top_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .timer_a_enable_i(timer_a_enable_i), .timer_a_overflow_i(timer_a_overflow_i),
    .high_osc_ready_i(high_osc_ready_i), .external_high_osc_run_o(external_high_osc_run_o),
    .internal_low_rc_run_o(internal_low_rc_run_o), .sys_clk_low_sel_o(sys_clk_low_sel_o),
    .cpu_run_o(cpu_run_o), .cpu_tick_o(cpu_tick_o), .timer_a_active_o(timer_a_active_o),
    .timer_b_active_o(timer_b_active_o), .timer_a_int_gate_o(timer_a_int_gate_o),
    .other_int_gate_o(other_int_gate_o), .ext_int_gate_o(ext_int_gate_o), .wake_pulse_o(wake_pulse_o));

// ---- verif/tb_power_mode_wakeup_control.sv ----
// Self-checking bench for the power mode and wakeup controller.
`timescale 1ns/10ps
`include "pmwc_defines.svh"

module tb_power_mode_wakeup_control;
    localparam logic [7:0] MC = `PMWC_MODE_CTRL_OFS;
    localparam logic [7:0] ST = `PMWC_STATUS_OFS;
    localparam logic [7:0] WE = `PMWC_P1_WAKE_EN_OFS;
    logic clk_i = 0, rst_i = 1, wr = 0, rd = 0, ta_en = 0, oreq = 0, rd_pend = 0;
    logic [7:0] addr = 0, wdata = 0, f0 = 0, f1 = 0, rdata, p0, p1, rv;
    logic osc, lrc, low, run, tick, taa, tba, tag, oig, eig, wp, ovf, rdy;
    logic [7:0] exp_q[$];
    int errors = 0, checks_done = 0, seed = 32'ha556, n;

    initial forever #2 clk_i = ~clk_i;

    pmwc_top DUT (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .port0_pins_i(p0), .port1_pins_i(p1), .timer_a_enable_i(ta_en),
        .timer_a_overflow_i(ovf), .timer_b_enable_i(ta_en), .high_osc_ready_i(rdy),
        .external_high_osc_run_o(osc), .internal_low_rc_run_o(lrc), .sys_clk_low_sel_o(low),
        .cpu_run_o(run), .cpu_tick_o(tick), .timer_a_active_o(taa), .timer_b_active_o(tba),
        .timer_a_int_gate_o(tag), .other_int_gate_o(oig), .ext_int_gate_o(eig), .wake_pulse_o(wp));

    pmwc_wake_src #(.STARTUP(20)) u_src (.clk_i(clk_i), .run_i(osc), .p0_flip_i(f0), .p1_flip_i(f1),
        .ovf_i(oreq), .p0_o(p0), .p1_o(p1), .ovf_o(ovf), .ready_o(rdy));

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        checks_done++;
        if (seen !== want)
        begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk_i);
    endtask

    task automatic wrr(input logic [7:0] a, input logic [7:0] d);
        {wr, addr, wdata} <= {1'b1, a, d};
        cyc(1);
        wr <= 1'b0;
        cyc(1);
    endtask

    // The read result is noted here and compared by the monitor one cycle later.
    task automatic rdr(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        {rd, addr} <= {1'b1, a};
        cyc(1);
        rd <= 1'b0;
        cyc(1);
    endtask

    task automatic kick(input logic [7:0] a, input logic [7:0] b, input logic o);
        {f0, f1, oreq} <= {a, b, o};
        cyc(1);
        {f0, f1, oreq} <= 17'h0;
        cyc(1);
    endtask

    task automatic wait_hi(ref logic s);
        n = 0;
        while (s !== 1'b1 && n < 5000)
        begin
            cyc(1);
            n++;
        end
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge clk_i)
    begin
        if (rd_pend)
            check(rdata, exp_q.pop_front());
        rd_pend <= rd;
    end

    initial
    begin
        cyc(20000);
        errors++;
        conclude();
    end

    initial
    begin
        cyc(10);
        rst_i <= 1'b0;
        check({osc, lrc, run, tick, tag, oig, eig, wp}, 8'hfe);
        rdr(MC, 8'h00);
        rdr(ST, 8'h01);
        wrr(WE, 8'h01);
        rdr(WE, 8'h00);
        rdr(8'h55, 8'h00);
        wrr(MC, 8'h04);
        rdr(ST, 8'h02);
        wrr(MC, 8'h06);
        check({5'h0, osc, lrc, low}, 8'h03);
        wrr(MC, 8'h02);
        rdr(ST, 8'h02);
        wrr(MC, 8'h04);
        wait_hi(rdy);
        cyc(40);
        wrr(MC, 8'h00);
        rdr(ST, 8'h01);
        wrr(MC, 8'h18);
        rdr(MC, 8'h00);
        wrr(MC, 8'h04);
        wrr(MC, 8'h14);
        check({7'h0, run}, 8'h00);
        kick(8'h00, 8'h02, 1'b1);
        cyc(3);
        rdr(ST, 8'h04);
        ta_en <= 1'b1;
        kick(8'h00, 8'h00, 1'b1);
        cyc(2);
        rdr(ST, 8'h82);
        rdr(MC, 8'h04);
        wrr(MC, 8'h14);
        kick(8'h00, 8'h01, 1'b0);
        cyc(2);
        rdr(ST, 8'h42);
        wrr(MC, 8'h0c);
        check({5'h0, osc, lrc, run}, 8'h00);
        kick(8'h00, 8'h00, 1'b1);
        cyc(3);
        rdr(ST, 8'h48);
        rv = 8'($random(seed));
        kick(rv | 8'h01, 8'h00, 1'b0);
        wait_hi(run);
        check({7'h0, n >= 2048}, 8'h01);
        cyc(2);
        rdr(MC, 8'h00);
        rdr(ST, 8'h21);
        // Green entered from normal must come back to normal on an enabled port 1 change.
        wrr(MC, 8'h10);
        rdr(ST, 8'h24);
        kick(8'h00, 8'h01, 1'b0);
        cyc(1);
        check({7'h0, wp}, 8'h01);
        cyc(1);
        rdr(ST, 8'h41);
        cyc(2);
        conclude();
    end
endmodule
